// ---- logic/serial_baud_rate_generator.sv ----
/*
  baud rate generator of the enhanced serial port, with its control
  registers behind an axi4-lite slave and the receive-pin majority
  sampler. assumes one clock, aclk, standing in for the device clock.
*/

// Notes on behaviour
// - async, 8-bit divisor, low speed: bit period is 64 times divisor plus one.
// - async, 8-bit divisor, high speed: bit period is 16 times divisor plus one.
// - async, 16-bit divisor, low speed: bit period is 16 times divisor plus one.
// - sync, 8-bit divisor: period 4 times divisor plus one, high speed ignored.
// - divisor is high byte above low byte.
// - high and low divisor bytes are separate registers.
// - receive level is the majority of three samples.
// - 8-bit divisor by default; wide select enables high byte.
// - any divisor write clears the rate counters at once.
`timescale 1ns/1ps
`default_nettype none
module serial_baud_rate_generator (
  // clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // axi4-lite write address
  input  wire logic [rate_gen_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output var  logic                             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output var  logic                             s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]                       s_axi_bresp,
  output var  logic                             s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // axi4-lite read address
  input  wire logic [rate_gen_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output var  logic                             s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]                      s_axi_rdata,
  output var  logic [1:0]                       s_axi_rresp,
  output var  logic                             s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // serial side
  input  wire logic                             rx_pin,
  output var  logic                             rx_level,
  // rate outputs
  output var  logic                             rate_tick,
  output var  logic                             bit_tick,
  output var  logic                             sync_mode,
  output var  logic                             port_enable
);
  import rate_gen_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]        tx_ctrl_r;
  logic [7:0]        rx_ctrl_r;
  logic [7:0]        rate_ctrl_r;
  logic [7:0]        div_high_r;
  logic [7:0]        div_low_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic [15:0]       div_cnt_r;
  logic [15:0]       div_cnt_nxt;
  logic [6:0]        pre_cnt_r;
  logic [6:0]        pre_cnt_nxt;
  logic              voted_level;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire       aw_take   = s_axi_awvalid & s_axi_awready;
  wire       w_take    = s_axi_wvalid & s_axi_wready;
  wire       wr_fire   = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire       b_done    = s_axi_bvalid & s_axi_bready;
  wire       wr_lane   = wr_fire & wlane_r;
  wire       sel_tx    = (awaddr_r == OFS_TX_CTRL);
  wire       sel_rx    = (awaddr_r == OFS_RX_CTRL);
  wire       sel_rc    = (awaddr_r == OFS_RATE_CTRL);
  wire       sel_dh    = (awaddr_r == OFS_DIV_HIGH);
  wire       sel_dl    = (awaddr_r == OFS_DIV_LOW);
  wire       sel_st    = (awaddr_r == OFS_STATUS);
  wire       wr_mapped = sel_tx | sel_rx | sel_rc | sel_dh | sel_dl | sel_st;
  wire       wr_tx     = wr_lane & sel_tx;
  wire       wr_rx     = wr_lane & sel_rx;
  wire       wr_rc     = wr_lane & sel_rc;
  wire       wr_dh     = wr_lane & sel_dh;
  wire       wr_dl     = wr_lane & sel_dl;
  wire       div_write = wr_dh | wr_dl;

  // ---------------------------------------------------------------
  // write channels
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      awaddr_r      <= '0;
      wbyte_r       <= REG_RESET;
      wlane_r       <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      aw_full_r     <= (aw_full_r | aw_take) & ~b_done;
      w_full_r      <= (w_full_r | w_take) & ~b_done;
      s_axi_awready <= ~(aw_full_r | aw_take) | b_done;
      s_axi_wready  <= ~(w_full_r | w_take) | b_done;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ctrl_r   <= REG_RESET;
      rx_ctrl_r   <= REG_RESET;
      rate_ctrl_r <= REG_RESET;
    end else begin
      if (wr_tx) begin
        tx_ctrl_r <= wbyte_r & TX_WR_MASK;
      end
      if (wr_rx) begin
        rx_ctrl_r <= wbyte_r & RX_WR_MASK;
      end
      if (wr_rc) begin
        rate_ctrl_r <= wbyte_r & RC_WR_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_high_r <= REG_RESET;
      div_low_r  <= REG_RESET;
    end else begin
      if (wr_dh) begin
        div_high_r <= wbyte_r;
      end
      if (wr_dl) begin
        div_low_r <= wbyte_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_mode   <= 1'b0;
      port_enable <= 1'b0;
    end else begin
      sync_mode   <= tx_ctrl_r[SYNC_BIT];
      port_enable <= rx_ctrl_r[PORT_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // prescale and divisor selection
  // ---------------------------------------------------------------
  wire        is_sync  = tx_ctrl_r[SYNC_BIT];
  wire        is_fast  = tx_ctrl_r[HIGH_SPEED_BIT];
  wire        is_wide  = rate_ctrl_r[WIDE_DIV_BIT];
  wire [15:0] divisor  = is_wide ? {div_high_r, div_low_r} : {8'h00, div_low_r};
  wire        use_slow = ~is_sync & ~is_wide & ~is_fast;
  wire        use_mid  = ~is_sync & (is_wide ^ is_fast);
  wire [6:0]  prescale = use_slow ? PRESCALE_SLOW :
                         use_mid  ? PRESCALE_MID  : PRESCALE_FAST;
  wire [6:0]  pre_last = prescale - 7'h01;

  // ---------------------------------------------------------------
  // rate counters
  // ---------------------------------------------------------------
  wire div_wrap = (div_cnt_r >= divisor);
  wire pre_wrap = div_wrap & (pre_cnt_r >= pre_last);

  always_comb begin
    div_cnt_nxt = div_wrap ? 16'h0000 : div_cnt_r + 16'h0001;
    pre_cnt_nxt = pre_cnt_r;
    if (div_wrap) begin
      pre_cnt_nxt = pre_wrap ? 7'h00 : pre_cnt_r + 7'h01;
    end
    if (div_write) begin
      div_cnt_nxt = 16'h0000;
      pre_cnt_nxt = 7'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 16'h0000;
      pre_cnt_r <= 7'h00;
      rate_tick <= 1'b0;
      bit_tick  <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      rate_tick <= div_wrap & ~div_write;
      bit_tick  <= pre_wrap & ~div_write;
    end
  end

  // ---------------------------------------------------------------
  // receive sampling
  // ---------------------------------------------------------------
  // vote on each rate tick
  majority_sampler u_sampler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .rx_pin    (rx_pin),
    .sample_en (rate_tick),
    .level     (voted_level)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_level <= 1'b1;
    end else begin
      rx_level <= voted_level;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  wire        ar_take   = s_axi_arvalid & s_axi_arready;
  wire        r_done    = s_axi_rvalid & s_axi_rready;
  wire        rd_tx     = (s_axi_araddr == OFS_TX_CTRL);
  wire        rd_rx     = (s_axi_araddr == OFS_RX_CTRL);
  wire        rd_rc     = (s_axi_araddr == OFS_RATE_CTRL);
  wire        rd_dh     = (s_axi_araddr == OFS_DIV_HIGH);
  wire        rd_dl     = (s_axi_araddr == OFS_DIV_LOW);
  wire        rd_st     = (s_axi_araddr == OFS_STATUS);
  wire        rd_mapped = rd_tx | rd_rx | rd_rc | rd_dh | rd_dl | rd_st;
  wire [7:0]  status    = {pre_cnt_r, voted_level};
  wire [7:0]  rd_byte   = ({8{rd_tx}} & (tx_ctrl_r | TX_RO_VALUE))   |
                          ({8{rd_rx}} & (rx_ctrl_r | RX_RO_VALUE))   |
                          ({8{rd_rc}} & (rate_ctrl_r | RC_RO_VALUE)) |
                          ({8{rd_dh}} & div_high_r)                  |
                          ({8{rd_dl}} & div_low_r)                   |
                          ({8{rd_st}} & status);

  // ---------------------------------------------------------------
  // read channels
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (r_done) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end
endmodule // serial_baud_rate_generator
`default_nettype wire

// ---- shared/rate_gen_pkg.sv ----
/*
  constants for the serial port rate generator: register byte offsets,
  field positions, reset values, write masks and prescale factors.
  assumes a 32-bit axi4-lite register bus, one aligned word per register.
*/
`default_nettype none
package rate_gen_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  OFS_TX_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_RX_CTRL      = 8'h04;
  localparam logic [7:0]  OFS_RATE_CTRL    = 8'h08;
  localparam logic [7:0]  OFS_DIV_HIGH     = 8'h0c;
  localparam logic [7:0]  OFS_DIV_LOW      = 8'h10;
  localparam logic [7:0]  OFS_STATUS       = 8'h14;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          SYNC_BIT         = 4;
  localparam int          HIGH_SPEED_BIT   = 2;
  localparam int          PORT_ENABLE_BIT  = 7;
  localparam int          WIDE_DIV_BIT     = 3;
  // ---------------------------------------------------------------
  // write masks, read-only values and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  TX_WR_MASK       = 8'hfd;
  localparam logic [7:0]  TX_RO_VALUE      = 8'h02;
  localparam logic [7:0]  RX_WR_MASK       = 8'hf8;
  localparam logic [7:0]  RX_RO_VALUE      = 8'h00;
  localparam logic [7:0]  RC_WR_MASK       = 8'h9b;
  localparam logic [7:0]  RC_RO_VALUE      = 8'h40;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  // ---------------------------------------------------------------
  // prescale factors and sampling
  // ---------------------------------------------------------------
  localparam logic [6:0]  PRESCALE_SLOW    = 7'h40;
  localparam logic [6:0]  PRESCALE_MID     = 7'h10;
  localparam logic [6:0]  PRESCALE_FAST    = 7'h04;
  localparam logic [2:0]  SAMPLE_IDLE      = 3'h7;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage
`default_nettype wire

// ---- logic/majority_sampler.sv ----
/*
  receive pin synchroniser and three-sample majority vote.
  assumes the pin is asynchronous to aclk and sample_en is a one-cycle
  pulse on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module majority_sampler (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and sampling strobe
  input  wire logic rx_pin,
  input  wire logic sample_en,
  // voted level
  output var  logic level
);
  import rate_gen_pkg::*;

  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;
  logic       stable_r;
  logic [2:0] samp_r;
  logic       vote;

  // ---------------------------------------------------------------
  // three-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r  <= 1'b1;
      sync2_r  <= 1'b1;
      sync3_r  <= 1'b1;
      stable_r <= 1'b1;
    end else begin
      sync1_r <= rx_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        stable_r <= sync3_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // majority vote
  // ---------------------------------------------------------------
  // two of three
  assign vote = (samp_r[0] & samp_r[1]) | (samp_r[1] & samp_r[2]) |
                (samp_r[0] & samp_r[2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_r <= SAMPLE_IDLE;
      level  <= 1'b1;
    end else begin
      if (sample_en) begin
        samp_r <= {samp_r[1:0], stable_r};
      end
      level <= vote;
    end
  end
endmodule // majority_sampler
`default_nettype wire

// ---- tb/rate_gen_props.sv ----
/* assertions on the rate generator ports.
   assumes the bind below onto serial_baud_rate_generator. */
`timescale 1ns/1ps
`default_nettype none
module rate_gen_props (
  // bus and ticks
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rate_tick,
  input wire logic        bit_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    !s_axi_bvalid ##[1:3] s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_taken |=> b_answer)
    else $error("write response late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("rvalid dropped");
  a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // ---------------------------------------------------------------
  // rate ticks
  // ---------------------------------------------------------------
  a_tick_pair: assert property (bit_tick |-> rate_tick)
    else $error("bit tick without rate tick");
  a_bit_single: assert property (bit_tick |=> !bit_tick)
    else $error("bit ticks too close");
endmodule // rate_gen_props
bind serial_baud_rate_generator rate_gen_props i_rate_gen_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .rate_tick, .bit_tick
);
`default_nettype wire

// ---- tb/remote_line.sv ----
/* far-end transceiver driving the receive pin.
   assumes requests change on aclk; the bench holds it idle high. */
`timescale 1ns/1ps
`default_nettype none
module remote_line (
  // clock and request
  input  wire logic aclk,
  input  wire logic level_req,
  // receive line
  output var  logic rx_pin
);
  always_ff @(posedge aclk) rx_pin <= level_req;
endmodule // remote_line
`default_nettype wire

// ---- tb/tb_serial_baud_rate_generator.sv ----
/* bench for the rate generator: bus tasks, rate and receive scenarios.
   assumes the remote_line partner and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_baud_rate_generator;
  import rate_gen_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0]  ws = 0;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, lvl = 1;
  logic        awr, wrd, bv, arr, rv, rxp, rxl, rt, bt, sm, pe;
  logic [1:0]  bre, rre;
  logic [31:0] rd;
  int          err_total = 0, check_count = 0;
  bit          slow_ack = 1'b0;
  serial_baud_rate_generator i_serial_baud_rate_generator (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .rx_pin(rxp), .rx_level(rxl), .rate_tick(rt), .bit_tick(bt),
    .sync_mode(sm), .port_enable(pe));
  remote_line i_remote_line (.aclk(aclk), .level_req(lvl), .rx_pin(rxp));
  initial forever #5 aclk = ~aclk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic lapse;
    err_total++;
    close_out();
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [3:0] s, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= ~slow_ack;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (br && bv === 1'b1) break;
      if (bv === 1'b1) br <= 1'b1;
    end
    br <= 1'b0;
    r = bre;
    if (i == 99) lapse();
  endtask
  task automatic w8(input logic [7:0] a, d);
    logic [1:0] r;
    wr(a, d, 4'h1, r);
    chk("bresp", r, RESP_OKAY);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= ~slow_ack;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rr && rv === 1'b1) break;
      if (rv === 1'b1) rr <= 1'b1;
    end
    rr <= 1'b0;
    d = rd;
    r = rre;
    if (i == 99) lapse();
  endtask
  task automatic rchk(input logic [7:0] a, e);
    logic [31:0] d;
    logic [1:0]  r;
    rdr(a, d, r);
    chk("rdata", d, {24'h0, e});
    chk("rresp", r, RESP_OKAY);
  endtask
  task automatic seek(input bit b, output int n);
    for (n = 1; n < 20000; n++) begin
      @(posedge aclk);
      if (b ? bt : rt) break;
    end
    if (n == 20000) lapse();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reg_file;
    logic [7:0]  o [5] = '{OFS_TX_CTRL, OFS_RX_CTRL, OFS_RATE_CTRL, OFS_DIV_HIGH, OFS_DIV_LOW};
    logic [7:0]  m [5] = '{TX_WR_MASK, RX_WR_MASK, RC_WR_MASK, 8'hff, 8'hff};
    logic [7:0]  v [5] = '{TX_RO_VALUE, RX_RO_VALUE, RC_RO_VALUE, 8'h00, 8'h00};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (o[k]) rchk(o[k], REG_RESET | v[k]);
    foreach (o[k]) w8(o[k], 8'hff);
    foreach (o[k]) rchk(o[k], m[k] | v[k]);
    chk("sync_mode", sm, 1'b1);
    chk("port_enable", pe, 1'b1);
    w8(OFS_DIV_HIGH, 8'ha5);
    w8(OFS_DIV_LOW, 8'h3c);
    wr(OFS_DIV_LOW, 8'h00, 4'h0, r);
    chk("strobe off", r, RESP_OKAY);
    rchk(OFS_DIV_HIGH, 8'ha5);
    rchk(OFS_DIV_LOW, 8'h3c);
    // late bready and rready hold the answers
    slow_ack = 1'b1;
    wr(8'h18, 8'hff, 4'h1, r);
    chk("unmapped bresp", r, RESP_SLVERR);
    rdr(8'h18, d, r);
    chk("unmapped rresp", r, RESP_SLVERR);
    chk("unmapped rdata", d, 32'h0);
    slow_ack = 1'b0;
  endtask
  task automatic rates;
    logic [7:0] t [7] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10, 8'h10};
    logic [7:0] c [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08};
    logic [7:0] h [7] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
    logic [7:0] l [7] = '{8'h02, 8'h02, 8'h00, 8'h05, 8'h05, 8'h03, 8'h03};
    int         p [7] = '{64, 16, 16, 4, 4, 4, 4};
    int         n, q;
    foreach (t[k]) begin
      w8(OFS_TX_CTRL, t[k]);
      w8(OFS_RATE_CTRL, c[k]);
      w8(OFS_DIV_HIGH, h[k]);
      w8(OFS_DIV_LOW, l[k]);
      q = c[k][WIDE_DIV_BIT] ? {h[k], l[k]} + 1 : l[k] + 1;
      seek(1'b0, n);
      seek(1'b0, n);
      chk("rate period", n, q);
      seek(1'b1, n);
      seek(1'b1, n);
      chk("bit period", n, p[k] * q);
      chk("sync_mode", sm, t[k][SYNC_BIT]);
    end
  endtask
  task automatic restart;
    int n;
    w8(OFS_TX_CTRL, 8'h00);
    w8(OFS_RATE_CTRL, 8'h00);
    w8(OFS_DIV_LOW, 8'hff);
    repeat (8000) @(posedge aclk);
    w8(OFS_DIV_LOW, 8'h00);
    seek(1'b1, n);
    chk("restart", n > 58 && n < 70, 1'b1);
  endtask
  task automatic line;
    int          i;
    logic [31:0] d;
    logic [1:0]  r;
    w8(OFS_DIV_LOW, 8'h07);
    @(posedge aclk);
    lvl <= 1'b0;
    repeat (8) @(posedge aclk);
    lvl <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      chk("one sample", rxl, 1'b1);
    end
    w8(OFS_DIV_LOW, 8'h00);
    @(posedge aclk);
    lvl <= 1'b0;
    for (i = 0; i < 40 && rxl !== 1'b0; i++) @(posedge aclk);
    chk("rx_level low", rxl, 1'b0);
    lvl <= 1'b1;
    @(posedge aclk);
    lvl <= 1'b0;
    repeat (20) begin
      @(posedge aclk);
      chk("glitch", rxl, 1'b0);
    end
    rdr(OFS_STATUS, d, r);
    chk("status level", d[0], 1'b0);
    lvl <= 1'b1;
    for (i = 0; i < 40 && rxl !== 1'b1; i++) @(posedge aclk);
    chk("rx_level high", rxl, 1'b1);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    reg_file();
    rates();
    restart();
    line();
    close_out();
  end
endmodule // tb_serial_baud_rate_generator
`default_nettype wire
